// [gpfc_pkg.sv]
/*
  Constants for the global pin and floppy resource configuration bank:
  register offsets, reset values, writable-bit masks, field positions,
  mode codes and timing figures.
  Assumes a single 125 MHz system clock.
*/
package gpfc_pkg;

  typedef logic [7:0] gpfc_byte_type;

  localparam int NUM_REGS      = 10;
  localparam int IDX_OUT_TYPE  = 0;
  localparam int IDX_TWO_WIRE  = 1;
  localparam int IDX_PORT_ONE  = 2;
  localparam int IDX_DEBOUNCE  = 3;
  localparam int IDX_TEST_A    = 4;
  localparam int IDX_TEST_B    = 5;
  localparam int IDX_FDC_ACT   = 6;
  localparam int IDX_FDC_HI    = 7;
  localparam int IDX_FDC_LO    = 8;
  localparam int IDX_FDC_IRQ   = 9;
  localparam int IDX_FDC_FIRST = IDX_FDC_ACT;

  localparam gpfc_byte_type OFF_OUT_TYPE = 8'h29;
  localparam gpfc_byte_type OFF_TWO_WIRE = 8'h2A;
  localparam gpfc_byte_type OFF_PORT_ONE = 8'h2C;
  localparam gpfc_byte_type OFF_DEBOUNCE = 8'h2D;
  localparam gpfc_byte_type OFF_TEST_A   = 8'h2E;
  localparam gpfc_byte_type OFF_TEST_B   = 8'h2F;
  localparam gpfc_byte_type OFF_FDC_ACT  = 8'h30;
  localparam gpfc_byte_type OFF_FDC_HI   = 8'h60;
  localparam gpfc_byte_type OFF_FDC_LO   = 8'h61;
  localparam gpfc_byte_type OFF_FDC_IRQ  = 8'h70;

  localparam gpfc_byte_type REG_OFFSET [NUM_REGS] = '{
    OFF_OUT_TYPE, OFF_TWO_WIRE, OFF_PORT_ONE, OFF_DEBOUNCE, OFF_TEST_A,
    OFF_TEST_B, OFF_FDC_ACT, OFF_FDC_HI, OFF_FDC_LO, OFF_FDC_IRQ};
  localparam gpfc_byte_type REG_RESET [NUM_REGS] = '{
    8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h01, 8'h03, 8'hF0, 8'h06};
  localparam gpfc_byte_type REG_WMASK [NUM_REGS] = '{
    8'hFE, 8'h0E, 8'hC7, 8'h77, 8'hFF, 8'hFF, 8'h01, 8'h0F, 8'hF8, 8'h0F};

  localparam int OT_GRP6_BIT  = 7;
  localparam int OT_ALERT_BIT = 6;
  localparam int OT_GRP5_BIT  = 5;
  localparam int OT_GRP4_BIT  = 4;
  localparam int OT_GRP3_BIT  = 3;
  localparam int OT_LED_LSB   = 1;
  localparam int TW_SDA_BYP   = 3;
  localparam int TW_SCL_BYP   = 2;
  localparam int TW_PIN_SEL   = 1;
  localparam int PM_GRP2_BIT  = 7;
  localparam int PM_GRP1_BIT  = 6;
  localparam int PM_THERM_BIT = 2;
  localparam int PM_FUNC_LSB  = 0;
  localparam int DB_DIS_LSB   = 4;
  localparam int DB_LVL_LSB   = 0;
  localparam int FA_ACT_BIT   = 0;

  localparam logic [1:0] LED_TRI = 2'h0;
  localparam logic [1:0] LED_LOW = 2'h1;
  localparam logic [1:0] LED_1HZ = 2'h2;
  localparam logic [1:0] LED_QHZ = 2'h3;
  localparam logic [1:0] PF_RSVD = 2'h0;
  localparam logic [1:0] PF_IR   = 2'h1;
  localparam logic [1:0] PF_GPIO = 2'h2;
  localparam logic [1:0] PF_UART = 2'h3;

  localparam int CLK_MHZ      = 125;
  localparam int LED_HALF_MS  = 500;
  localparam int LED_HALF_CYC = LED_HALF_MS * CLK_MHZ * 1000;
  localparam int FILT_NS      = 50;
  localparam int FILT_CYC     = (FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int FILT_W       = 3;
  localparam int DEB_US       = 16;
  localparam int DEB_CYC      = DEB_US * CLK_MHZ;
  localparam int DEB_W        = 11;

endpackage

// [gpfc_config_bank.sv]
/*
  Global pin configuration and floppy resource register bank with the
  pin muxing, output-type, LED blink, filter and debounce logic it steers.
  Assumes the configuration port, lock bit and logical-device select come
  from logic on clk_sys; pin inputs are asynchronous.
*/
// Notes on behaviour
// R1: Bit 7 of 29h: group six open-drain at 0, push-pull at 1.
// R2: Bit 6 of 29h routes shared pin to overtemp (0) or management irq (1).
// R3: Bit 5 of 29h: group five open-drain at 0, push-pull at 1.
// R4: Bit 4 of 29h: group four open-drain at 0, push-pull at 1.
// R5: Bit 3 of 29h: group three open-drain at 0, push-pull at 1.
// R6: LED mode: off, low, 1 Hz square, quarter-hertz square.
// R7: Bit 3 of 2Ah: data input filtered at 0, bypassed at 1.
// R8: Bit 2 of 2Ah: clock input filtered at 0, bypassed at 1.
// R9: Bit 1 of 2Ah: shared pins are port bits (0) or two-wire lines (1).
// R10: Bit 7 of 2Ch: group two open-drain at 0, push-pull at 1.
// R11: Bit 6 of 2Ch: group one open-drain at 0, push-pull at 1.
// R12: Bit 2 of 2Ch enables thermal shutdown; battery-backed bit. The code resets it with the system reset.
// R13: Port-one function field picks reserved, infrared, all port, or serial.
// R14: Debounce bits 4 to 6 enable debouncer at 0, disable at 1.
// R15: Bits 0 to 2 pick edge (0) or level (1) triggering.
// R16: Two test registers are plain eight-bit stores reset to zero.
// R17: Floppy activation bit 0: inactive at 0, active at 1; reset 01h.
// R18: Floppy base spans 100h to FF8h on 8-byte steps; reset 3F0h. The code also accepts bases below 100h, down to 000h.
// R19: Low four bits of 70h pick floppy interrupt; reset 06h.
// R20: While lock is set, register reads and writes are refused.
// R21: Reserved bits read zero, ignore writes; reset loads defaults.
`timescale 1ns/1ps

module gpfc_config_bank
  import gpfc_pkg::*;
#(
  parameter int LED_HALF_CYCLES = LED_HALF_CYC
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // Configuration port
  input  wire logic       cfg_wr_en,
  input  wire logic       cfg_rd_en,
  input  wire logic [7:0] cfg_addr,
  input  wire logic [7:0] cfg_wdata,
  input  wire logic       config_lock,
  input  wire logic       floppy_selected,
  output logic      [7:0] cfg_rdata_q,
  output logic            cfg_rvalid_q,
  // Port group output types, bit 0 is group one
  output logic      [5:0] grp_push_pull_q,
  // Shared alert pin
  input  wire logic       overtemp_out_n,
  input  wire logic       hwmon_mgmt_irq_n,
  output logic            alert_pin_n_q,
  // Power LED pin
  output logic            power_led_out_q,
  output logic            power_led_oe_n_q,
  // Shared two-wire pins and their sources
  input  wire logic       pin_a_in,
  input  wire logic       pin_b_in,
  input  wire logic       port_pin_two_seven_in,
  input  wire logic       port_pin_two_five_out,
  input  wire logic       port_pin_two_five_oe_n,
  input  wire logic       port_pin_two_six_out,
  input  wire logic       port_pin_two_six_oe_n,
  input  wire logic       sda_drive_low,
  input  wire logic       scl_drive_low,
  output logic            pin_a_out_q,
  output logic            pin_a_oe_n_q,
  output logic            pin_b_out_q,
  output logic            pin_b_oe_n_q,
  output logic            sda_in_q,
  output logic            scl_in_q,
  // Debounced port inputs, bit 0 is pin two-five
  output logic      [2:0] port_pin_in_q,
  output logic      [2:0] port_pin_event_q,
  // Port one function and thermal control
  output logic            infrared_enable_q,
  output logic            serial_b_enable_q,
  output logic            pin83_hold_low_q,
  output logic            thermal_shutdown_enable_q,
  // Floppy controller resources
  output logic            floppy_controller_active_q,
  output logic     [11:0] floppy_base_addr_q,
  output logic      [3:0] floppy_irq_sel_q
);

  //////////////////////////////////////////////////////////////////////////

  function automatic logic [NUM_REGS-1:0] reg_hit(
    input gpfc_byte_type addr,
    input logic          fsel
  );
    logic [NUM_REGS-1:0] hit;
    hit = '0;
    for (int i = 0; i < NUM_REGS; i++) begin
      hit[i] = (addr == REG_OFFSET[i]) && ((i < IDX_FDC_FIRST) || fsel);
    end
    return hit;
  endfunction

  gpfc_byte_type       regs_q [NUM_REGS];
  logic [NUM_REGS-1:0] wr_hit_w;
  logic [NUM_REGS-1:0] rd_hit_w;
  gpfc_byte_type       rd_mux_w;

  // Thermal enable lives in the battery-backed well on silicon; here it
  // shares the system reset, so a real part must keep it across sleep.
  assign wr_hit_w = (cfg_wr_en && !config_lock) ?
                    reg_hit(cfg_addr, floppy_selected) : '0; // R20
  assign rd_hit_w = (cfg_rd_en && !config_lock) ?
                    reg_hit(cfg_addr, floppy_selected) : '0; // R20

  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < NUM_REGS; i++) begin
      if (!rst_n) begin
        regs_q[i] <= REG_RESET[i]; // R21
      end else if (wr_hit_w[i]) begin
        regs_q[i] <= cfg_wdata & REG_WMASK[i]; // R16
      end
    end
  end

  always_comb begin
    rd_mux_w = '0;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (rd_hit_w[i]) begin
        rd_mux_w = rd_mux_w | regs_q[i]; // R21
      end
    end
  end

  // A refused or unmapped read still answers, with 00h.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cfg_rvalid_q <= 1'b0;
      cfg_rdata_q  <= 8'h00;
    end else begin
      cfg_rvalid_q <= cfg_rd_en;
      cfg_rdata_q  <= rd_mux_w;
    end
  end

  gpfc_byte_type ot_w;
  gpfc_byte_type tw_w;
  gpfc_byte_type pm_w;
  gpfc_byte_type db_w;
  logic [1:0]    led_mode_w;
  logic [1:0]    pf_func_w;
  logic          two_wire_w;

  assign ot_w       = regs_q[IDX_OUT_TYPE];
  assign tw_w       = regs_q[IDX_TWO_WIRE];
  assign pm_w       = regs_q[IDX_PORT_ONE];
  assign db_w       = regs_q[IDX_DEBOUNCE];
  assign led_mode_w = ot_w[OT_LED_LSB +: 2];
  assign pf_func_w  = pm_w[PM_FUNC_LSB +: 2];
  assign two_wire_w = tw_w[TW_PIN_SEL];

  //////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      grp_push_pull_q <= 6'h00;
      alert_pin_n_q   <= 1'b1;
    end else begin
      grp_push_pull_q[5] <= ot_w[OT_GRP6_BIT]; // R1
      grp_push_pull_q[4] <= ot_w[OT_GRP5_BIT]; // R3
      grp_push_pull_q[3] <= ot_w[OT_GRP4_BIT]; // R4
      grp_push_pull_q[2] <= ot_w[OT_GRP3_BIT]; // R5
      grp_push_pull_q[1] <= pm_w[PM_GRP2_BIT]; // R10
      grp_push_pull_q[0] <= pm_w[PM_GRP1_BIT]; // R11
      alert_pin_n_q <= ot_w[OT_ALERT_BIT] ?
                       hwmon_mgmt_irq_n : overtemp_out_n; // R2
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      infrared_enable_q          <= 1'b0;
      serial_b_enable_q          <= 1'b0;
      pin83_hold_low_q           <= 1'b0;
      thermal_shutdown_enable_q  <= 1'b0;
      floppy_controller_active_q <= REG_RESET[IDX_FDC_ACT][FA_ACT_BIT];
      floppy_base_addr_q         <= {REG_RESET[IDX_FDC_HI][3:0],
                                     REG_RESET[IDX_FDC_LO]};
      floppy_irq_sel_q           <= REG_RESET[IDX_FDC_IRQ][3:0];
    end else begin
      infrared_enable_q <= (pf_func_w == PF_IR); // R13
      serial_b_enable_q <= (pf_func_w == PF_UART); // R13
      pin83_hold_low_q  <= (pf_func_w == PF_RSVD); // R13
      thermal_shutdown_enable_q <= pm_w[PM_THERM_BIT]; // R12
      floppy_controller_active_q <= regs_q[IDX_FDC_ACT][FA_ACT_BIT]; // R17
      floppy_base_addr_q <= {regs_q[IDX_FDC_HI][3:0],
                             regs_q[IDX_FDC_LO]}; // R18
      floppy_irq_sel_q <= regs_q[IDX_FDC_IRQ][3:0]; // R19
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Power LED: one tick every half second drives a phase counter, so the
  // quarter-hertz wave shares the divider instead of needing its own.

  logic [31:0] led_div_q;
  logic  [2:0] led_phase_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      led_div_q   <= 32'h0;
      led_phase_q <= 3'h0;
    end else if (led_div_q == 32'(LED_HALF_CYCLES - 1)) begin
      led_div_q   <= 32'h0;
      led_phase_q <= led_phase_q + 3'h1;
    end else begin
      led_div_q <= led_div_q + 32'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      power_led_out_q  <= 1'b0;
      power_led_oe_n_q <= 1'b1;
    end else begin
      unique case (led_mode_w)
        LED_TRI: begin
          power_led_out_q  <= 1'b0;
          power_led_oe_n_q <= 1'b1; // R6
        end
        LED_LOW: begin
          power_led_out_q  <= 1'b0;
          power_led_oe_n_q <= 1'b0; // R6
        end
        LED_1HZ: begin
          power_led_out_q  <= led_phase_q[0]; // R6
          power_led_oe_n_q <= 1'b0;
        end
        LED_QHZ: begin
          power_led_out_q  <= led_phase_q[2]; // R6
          power_led_oe_n_q <= 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin inputs: three flops, accepted when the last two agree.

  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] sync3_q;
  logic [2:0] pin_lvl_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync1_q   <= 3'h7;
      sync2_q   <= 3'h7;
      sync3_q   <= 3'h7;
      pin_lvl_q <= 3'h7;
    end else begin
      sync1_q <= {port_pin_two_seven_in, pin_b_in, pin_a_in};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      for (int i = 0; i < 3; i++) begin
        if (sync2_q[i] == sync3_q[i]) begin
          pin_lvl_q[i] <= sync3_q[i];
        end
      end
    end
  end

  // Glitch filter on the two-wire inputs: a level must hold FILT_CYC
  // cycles before it is passed on.
  logic [1:0] filt_w;
  logic [1:0] filt_byp_w;

  assign filt_byp_w = {tw_w[TW_SCL_BYP], tw_w[TW_SDA_BYP]};

  for (genvar k = 0; k < 2; k++) begin : g_filt
    logic [FILT_W-1:0] cnt_q;
    logic              lvl_q;
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        cnt_q <= '0;
        lvl_q <= 1'b1;
      end else if (pin_lvl_q[k] == lvl_q) begin
        cnt_q <= '0;
      end else if (cnt_q == FILT_W'(FILT_CYC - 1)) begin
        cnt_q <= '0;
        lvl_q <= pin_lvl_q[k];
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
    assign filt_w[k] = filt_byp_w[k] ? pin_lvl_q[k] : lvl_q; // R7 R8
  end

  // Debouncers for the three port inputs.
  logic [2:0] deb_w;
  logic [2:0] deb_prev_q;
  logic [2:0] deb_dis_w;
  logic [2:0] trig_lvl_w;
  logic [2:0] tw_gate_w;

  assign deb_dis_w  = db_w[DB_DIS_LSB +: 3];
  assign trig_lvl_w = db_w[DB_LVL_LSB +: 3];
  assign tw_gate_w  = {1'b0, two_wire_w, two_wire_w};

  for (genvar k = 0; k < 3; k++) begin : g_deb
    logic [DEB_W-1:0] cnt_q;
    logic             lvl_q;
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        cnt_q <= '0;
        lvl_q <= 1'b1;
      end else if (pin_lvl_q[k] == lvl_q) begin
        cnt_q <= '0;
      end else if (cnt_q == DEB_W'(DEB_CYC - 1)) begin
        cnt_q <= '0;
        lvl_q <= pin_lvl_q[k];
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
    assign deb_w[k] = deb_dis_w[k] ? pin_lvl_q[k] : lvl_q; // R14
  end

  // Pins taken by the two-wire lines read as idle port inputs.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      deb_prev_q       <= 3'h7;
      port_pin_in_q    <= 3'h7;
      port_pin_event_q <= 3'h0;
    end else begin
      deb_prev_q    <= deb_w;
      port_pin_in_q <= deb_w | tw_gate_w; // R9
      for (int i = 0; i < 3; i++) begin
        port_pin_event_q[i] <= !tw_gate_w[i] &&
          (trig_lvl_w[i] ? deb_w[i] : (deb_w[i] ^ deb_prev_q[i])); // R15
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Shared pins: two-wire lines only pull low; port bits follow their
  // group two output type.

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pin_a_out_q  <= 1'b0;
      pin_a_oe_n_q <= 1'b1;
      pin_b_out_q  <= 1'b0;
      pin_b_oe_n_q <= 1'b1;
      sda_in_q     <= 1'b1;
      scl_in_q     <= 1'b1;
    end else if (two_wire_w) begin
      pin_a_out_q  <= 1'b0; // R9
      pin_a_oe_n_q <= !sda_drive_low;
      pin_b_out_q  <= 1'b0;
      pin_b_oe_n_q <= !scl_drive_low;
      sda_in_q     <= filt_w[0]; // R7
      scl_in_q     <= filt_w[1]; // R8
    end else begin
      pin_a_out_q  <= port_pin_two_five_out;
      pin_a_oe_n_q <= port_pin_two_five_oe_n ||
        (!pm_w[PM_GRP2_BIT] && port_pin_two_five_out); // R10
      pin_b_out_q  <= port_pin_two_six_out;
      pin_b_oe_n_q <= port_pin_two_six_oe_n ||
        (!pm_w[PM_GRP2_BIT] && port_pin_two_six_out); // R10
      sda_in_q     <= 1'b1;
      scl_in_q     <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////

  logic [8*NUM_REGS-1:0] regs_flat_w;

  always_comb begin
    regs_flat_w = '0;
    for (int i = 0; i < NUM_REGS; i++) begin
      regs_flat_w[8*i +: 8] = regs_q[i];
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  chk_grp6_type: // R1
    assert property (cfg_wr_en && !config_lock && cfg_addr == OFF_OUT_TYPE
      |-> ##2 grp_push_pull_q[5] == $past(cfg_wdata[OT_GRP6_BIT], 2))
    else $error("group six type not taken from write");
  chk_alert_route: // R2
    assert property (ot_w[OT_ALERT_BIT]
      |=> alert_pin_n_q == $past(hwmon_mgmt_irq_n))
    else $error("alert pin not routed to management irq");
  chk_led_off: // R6
    assert property (led_mode_w == LED_TRI |=> power_led_oe_n_q)
    else $error("power led driven in tri-state mode");
  chk_sda_bypass: // R7
    assert property (two_wire_w && tw_w[TW_SDA_BYP]
      |=> sda_in_q == $past(pin_lvl_q[0]))
    else $error("data input not bypassing filter");
  chk_two_wire_pin: // R9
    assert property (two_wire_w
      |=> !pin_a_out_q && pin_a_oe_n_q == $past(!sda_drive_low))
    else $error("shared pin not acting as data line");
  chk_grp2_drain: // R10
    assert property (!two_wire_w && !pm_w[PM_GRP2_BIT]
      && port_pin_two_five_out |=> pin_a_oe_n_q)
    else $error("open-drain pin drove high");
  chk_therm_en: // R12
    assert property (##1 thermal_shutdown_enable_q
      == $past(pm_w[PM_THERM_BIT]))
    else $error("thermal enable mismatch");
  chk_ir_mode: // R13
    assert property (pf_func_w == PF_IR
      |=> infrared_enable_q && !serial_b_enable_q)
    else $error("infrared mode not selected");
  chk_deb_bypass: // R14
    assert property (deb_dis_w[2]
      |=> port_pin_in_q[2] == $past(pin_lvl_q[2]))
    else $error("debouncer not bypassed");
  chk_edge_pulse: // R15
    assert property (!trig_lvl_w[2] && !deb_dis_w[2]
      && port_pin_event_q[2] |=> !port_pin_event_q[2])
    else $error("edge event longer than one cycle");
  chk_base_align: // R18
    assert property (floppy_base_addr_q[2:0] == 3'h0)
    else $error("floppy base not on 8-byte boundary");
  chk_lock_write: // R20
    assert property (config_lock |=> $stable(regs_flat_w))
    else $error("register changed while locked");
  chk_lock_read: // R20
    assert property (cfg_rd_en && config_lock
      |=> cfg_rvalid_q && cfg_rdata_q == 8'h00)
    else $error("locked read returned data");
  chk_rsvd_zero: // R21
    assert property (cfg_rd_en && cfg_addr == OFF_OUT_TYPE
      |=> !cfg_rdata_q[0])
    else $error("reserved bit read as one");

endmodule // gpfc_config_bank

// [tb_top.sv]
/*
  Self-checking bench for the global pin and floppy resource bank.
  Assumes gpfc_pkg and gpfc_config_bank are compiled first and that one
  125 MHz clock drives everything; the bench plays the host and the pins.
*/
`timescale 1ns/1ps

module tb_top
  import gpfc_pkg::*;
;

  //////////////////////////////////////////////////////////////////////////
  logic        clk_sys = 1'b0, rst_n, cfg_wr_en, cfg_rd_en, config_lock;
  logic [7:0]  cfg_addr, cfg_wdata, cfg_rdata_q, rd_v;
  logic        floppy_selected, overtemp_out_n, hwmon_mgmt_irq_n, pin_a_in;
  logic        pin_b_in, port_pin_two_seven_in, port_pin_two_five_out;
  logic        port_pin_two_five_oe_n, port_pin_two_six_out, sda_drive_low;
  logic        port_pin_two_six_oe_n, scl_drive_low, cfg_rvalid_q;
  logic [5:0]  grp_push_pull_q;
  logic        alert_pin_n_q, power_led_out_q, power_led_oe_n_q, pin_a_out_q;
  logic        pin_a_oe_n_q, pin_b_out_q, pin_b_oe_n_q, sda_in_q, scl_in_q;
  logic [2:0]  port_pin_in_q, port_pin_event_q;
  logic        infrared_enable_q, serial_b_enable_q, pin83_hold_low_q;
  logic        thermal_shutdown_enable_q, floppy_controller_active_q;
  logic [11:0] floppy_base_addr_q;
  logic [3:0]  floppy_irq_sel_q;
  int          bad_count = 0;
  int          n_tests = 0;
  logic [7:0]  adr [10] = '{8'h29, 8'h2A, 8'h2C, 8'h2D, 8'h2E, 8'h2F,
                            8'h30, 8'h60, 8'h61, 8'h70};
  logic [7:0]  rst_v [10] = '{8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00,
                              8'h01, 8'h03, 8'hF0, 8'h06};
  logic [7:0]  msk [10] = '{8'hFE, 8'h0E, 8'hC7, 8'h77, 8'hFF, 8'hFF,
                            8'h01, 8'h0F, 8'hF8, 8'h0F};

  always #4 clk_sys = ~clk_sys;

  // A short blink half period keeps the LED checks to a few dozen cycles.
  gpfc_config_bank #(.LED_HALF_CYCLES(8)) dut_u (
    .clk_sys, .rst_n, .cfg_wr_en, .cfg_rd_en, .cfg_addr, .cfg_wdata,
    .config_lock, .floppy_selected, .cfg_rdata_q, .cfg_rvalid_q,
    .grp_push_pull_q, .overtemp_out_n, .hwmon_mgmt_irq_n, .alert_pin_n_q,
    .power_led_out_q, .power_led_oe_n_q, .pin_a_in, .pin_b_in,
    .port_pin_two_seven_in, .port_pin_two_five_out, .port_pin_two_five_oe_n,
    .port_pin_two_six_out, .port_pin_two_six_oe_n, .sda_drive_low,
    .scl_drive_low, .pin_a_out_q, .pin_a_oe_n_q, .pin_b_out_q, .pin_b_oe_n_q,
    .sda_in_q, .scl_in_q, .port_pin_in_q, .port_pin_event_q,
    .infrared_enable_q, .serial_b_enable_q, .pin83_hold_low_q,
    .thermal_shutdown_enable_q, .floppy_controller_active_q,
    .floppy_base_addr_q, .floppy_irq_sel_q);

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Returns a cycle and a half after the update edge so derived outputs have landed.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    cfg_wr_en = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge clk_sys);
    cfg_wr_en = 1'b0;
    @(negedge clk_sys);
  endtask

  // A missing valid pulse yields a marker value so the compare fails.
  task automatic rd(input logic [7:0] a);
    @(negedge clk_sys);
    cfg_rd_en = 1'b1;
    cfg_addr = a;
    @(negedge clk_sys);
    cfg_rd_en = 1'b0;
    rd_v = (cfg_rvalid_q === 1'b1) ? cfg_rdata_q : 8'hEE;
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    for (int i = 0; i < 10; i++) begin
      rd(adr[i]);
      chk(rd_v, rst_v[i]);
    end
    chk(floppy_controller_active_q, 1'b1);
    chk(floppy_base_addr_q, 12'h3F0);
    chk(floppy_irq_sel_q, 4'h6);
    chk(grp_push_pull_q, 6'h00);
  endtask

  task automatic t_mask();
    for (int i = 0; i < 10; i++) begin
      wr(adr[i], 8'hFF);
      rd(adr[i]);
      chk(rd_v, msk[i]);
    end
    chk(grp_push_pull_q, 6'h3F);
    chk(thermal_shutdown_enable_q, 1'b1);
    chk(serial_b_enable_q, 1'b1);
    chk(floppy_base_addr_q, 12'hFF8);
    chk(floppy_irq_sel_q, 4'hF);
    for (int i = 0; i < 10; i++) begin
      wr(adr[i], 8'h00);
      rd(adr[i]);
      chk(rd_v, 8'h00);
    end
    chk(floppy_controller_active_q, 1'b0);
  endtask

  task automatic t_groups();
    logic [7:0] ga [6] = '{8'h29, 8'h29, 8'h29, 8'h29, 8'h2C, 8'h2C};
    int         gb [6] = '{7, 5, 4, 3, 7, 6};
    int         gg [6] = '{5, 4, 3, 2, 1, 0};
    for (int i = 0; i < 6; i++) begin
      wr(ga[i], 8'h01 << gb[i]);
      chk(grp_push_pull_q, 6'h01 << gg[i]);
      wr(ga[i], 8'h00);
    end
    for (int f = 0; f < 4; f++) begin
      wr(8'h2C, 8'(f));
      chk({infrared_enable_q, serial_b_enable_q, pin83_hold_low_q},
          {f == 1, f == 3, f == 0});
    end
  endtask

  task automatic t_alert_lock();
    overtemp_out_n = 1'b0;
    wr(8'h29, 8'h00);
    chk(alert_pin_n_q, 1'b0);
    wr(8'h29, 8'h40);
    chk(alert_pin_n_q, 1'b1);
    hwmon_mgmt_irq_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk(alert_pin_n_q, 1'b0);
    wr(8'h2E, 8'h5A);
    config_lock = 1'b1;
    wr(8'h2E, 8'hA5);
    rd(8'h2E);
    chk(rd_v, 8'h00);
    config_lock = 1'b0;
    rd(8'h2E);
    chk(rd_v, 8'h5A);
    // Floppy registers only decode while that device is selected.
    floppy_selected = 1'b0;
    wr(8'h70, 8'h05);
    rd(8'h70);
    chk(rd_v, 8'h00);
    floppy_selected = 1'b1;
    chk(floppy_irq_sel_q, 4'h0);
  endtask

  task automatic led_gap(input int exp);
    logic last;
    int   n;
    n = 0;
    repeat (2) begin
      last = power_led_out_q;
      n = 0;
      while (power_led_out_q === last && n < 100) begin
        @(negedge clk_sys);
        n++;
      end
    end
    chk(n, exp);
    chk(power_led_oe_n_q, 1'b0);
  endtask

  task automatic t_led();
    wr(8'h29, 8'h02);
    chk({power_led_oe_n_q, power_led_out_q}, 2'b00);
    wr(8'h29, 8'h00);
    chk(power_led_oe_n_q, 1'b1);
    wr(8'h29, 8'h04);
    led_gap(8);
    wr(8'h29, 8'h06);
    led_gap(32);
  endtask

  // A four-cycle low glitch on both pins; returns which inputs saw it.
  task automatic glitch(output logic [1:0] low);
    low = 2'b00;
    pin_a_in = 1'b0;
    pin_b_in = 1'b0;
    repeat (4) @(negedge clk_sys);
    pin_a_in = 1'b1;
    pin_b_in = 1'b1;
    repeat (20) begin
      @(negedge clk_sys);
      low = low | {!sda_in_q, !scl_in_q};
    end
  endtask

  task automatic t_pins();
    logic [1:0] low;
    port_pin_two_five_oe_n = 1'b0;
    wr(8'h2A, 8'h00);
    chk({pin_a_oe_n_q, pin_a_out_q}, 2'b00);
    port_pin_two_five_out = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk({pin_a_oe_n_q, pin_a_out_q}, 2'b11);
    wr(8'h2C, 8'h80);
    chk({pin_a_oe_n_q, pin_a_out_q}, 2'b01);
    port_pin_two_five_out = 1'b0;
    wr(8'h2A, 8'h02);
    chk(pin_a_oe_n_q, 1'b1);
    sda_drive_low = 1'b1;
    scl_drive_low = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk({pin_a_oe_n_q, pin_a_out_q}, 2'b00);
    chk({pin_b_oe_n_q, pin_b_out_q}, 2'b00);
    sda_drive_low = 1'b0;
    scl_drive_low = 1'b0;
    glitch(low);
    chk(low, 2'b00);
    wr(8'h2A, 8'h0A);
    glitch(low);
    chk(low, 2'b10);
    wr(8'h2A, 8'h06);
    glitch(low);
    chk(low, 2'b01);
  endtask

  task automatic t_debounce();
    int n;
    n = 0;
    wr(8'h2D, 8'h70);
    port_pin_two_seven_in = 1'b0;
    repeat (20) begin
      @(negedge clk_sys);
      n += port_pin_event_q[2];
    end
    chk({n[3:0], port_pin_in_q[2]}, 5'h02);
    wr(8'h2D, 8'h74);
    port_pin_two_seven_in = 1'b1;
    repeat (20) @(negedge clk_sys);
    chk(port_pin_event_q[2], 1'b1);
    // The debouncer is far longer than this pulse, so it must be swallowed.
    wr(8'h2D, 8'h04);
    port_pin_two_seven_in = 1'b0;
    n = 0;
    repeat (40) begin
      @(negedge clk_sys);
      n += !port_pin_in_q[2];
    end
    port_pin_two_seven_in = 1'b1;
    chk(n, 0);
    // A held level passes after the full count: four sync cycles, the
    // debounce count and one output register.
    wr(8'h2D, 8'h00);
    repeat (8) @(negedge clk_sys);
    port_pin_two_seven_in = 1'b0;
    n = 0;
    while (port_pin_in_q[2] !== 1'b0 && n < 3000) begin
      @(negedge clk_sys);
      n++;
    end
    chk(n, DEB_CYC + 5);
    chk(port_pin_event_q[2], 1'b1);
    @(negedge clk_sys);
    chk(port_pin_event_q[2], 1'b0);
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, cfg_wr_en, cfg_rd_en, config_lock, sda_drive_low} = '0;
    {scl_drive_low, port_pin_two_five_out, port_pin_two_six_out} = '0;
    {port_pin_two_five_oe_n, port_pin_two_six_oe_n, floppy_selected} = '1;
    {overtemp_out_n, hwmon_mgmt_irq_n, pin_a_in, pin_b_in} = '1;
    port_pin_two_seven_in = 1'b1;
    cfg_addr = 8'h00;
    cfg_wdata = 8'h00;
    repeat (4) @(negedge clk_sys);
    rst_n = 1'b1;
    t_reset();
    t_mask();
    t_groups();
    t_alert_lock();
    t_led();
    t_pins();
    t_debounce();
    final_report();
  end

  // A hung scenario counts as a mismatch and still reaches the verdict.
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    final_report();
  end

endmodule // tb_top
